// ==== common/aux_ctrl_pkg.sv ====
`default_nettype none
package aux_ctrl_pkg;
   // =============================================
   // register map
   localparam logic [11:0] AUX_MONITOR_CONTROL_OFFS = 12'h370;
   localparam logic [11:0] DUPLEX_PIN_CONTROL_OFFS = 12'h24D;
   localparam logic [11:0] LP_PARALLEL_CLOCK_DELAY_OFFS = 12'h33D;
   localparam logic [11:0] LP_PARALLEL_DATA_DELAY_OFFS = 12'h33F;
   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   // =============================================
   // field positions
   localparam int AUX_WAKE_BIT = 6;
   localparam int AUX_INSEL_LSB = 3;
   localparam int DUPLEX_BY_PIN_BIT = 2;
   localparam int OUTCLK_SEL_LSB = 0;
   localparam int OUTDATA_SEL_LSB = 0;
   localparam int STEP_SEL_LSB = 3;
   // =============================================
   // codes and delay figures, delays in picoseconds
   localparam logic [1:0] AUX_IN_A = 2'h0;
   localparam logic [1:0] AUX_IN_B = 2'h1;
   localparam logic [2:0] DATA_SEL_NA = 3'h4;
   localparam logic [15:0] DELAY_OFFSET_PS = 16'h012C;

   typedef logic [11:0] step_ps_t;
   typedef logic [2:0] delay_units_t;

   function automatic step_ps_t step_to_ps(input logic [2:0] sel);
      case (sel)
         3'h0: step_to_ps = 12'h460;
         3'h1: step_to_ps = 12'h5DC;
         3'h2: step_to_ps = 12'h226;
         3'h3: step_to_ps = 12'h384;
         3'h4: step_to_ps = 12'h73A;
         3'h5: step_to_ps = 12'h898;
         3'h6: step_to_ps = 12'h4E2;
         default: step_to_ps = 12'h654;
      endcase
   endfunction

   function automatic delay_units_t clk_units(input logic [1:0] sel);
      case (sel)
         2'h0: clk_units = 3'h4;
         2'h1: clk_units = 3'h5;
         2'h2: clk_units = 3'h2;
         default: clk_units = 3'h3;
      endcase
   endfunction

   function automatic delay_units_t data_units(input logic [2:0] sel);
      case (sel)
         3'h0: data_units = 3'h4;
         3'h1: data_units = 3'h5;
         3'h2: data_units = 3'h6;
         3'h3: data_units = 3'h7;
         3'h5: data_units = 3'h1;
         3'h6: data_units = 3'h2;
         3'h7: data_units = 3'h3;
         default: data_units = 3'h0;
      endcase
   endfunction
endpackage
`default_nettype wire

// ==== core/lp_delay_decode.sv ====
`default_nettype none
module lp_delay_decode (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic lp_mode,
   input wire logic [1:0] clk_sel,
   input wire logic [2:0] data_sel,
   input wire logic [2:0] step_sel,
   output logic delay_active,
   output logic data_sel_invalid,
   output aux_ctrl_pkg::delay_units_t outclk_delay_units,
   output aux_ctrl_pkg::delay_units_t outdata_delay_units,
   output aux_ctrl_pkg::step_ps_t unit_delay_ps,
   output logic [15:0] outclk_delay_ps,
   output logic [15:0] outdata_delay_ps
);
   import aux_ctrl_pkg::*;

   logic [15:0] nxt_clk_ps;
   logic [15:0] nxt_data_ps;
   logic [15:0] step16;
   logic [2:0] cu;
   logic [2:0] du;

   // =============================================
   // decode
   always_comb begin
      cu = clk_units(clk_sel);
      du = data_units(data_sel);
      step16 = {4'h0, step_to_ps(step_sel)};
      nxt_clk_ps = 16'(16'({13'h0, cu} * step16) - DELAY_OFFSET_PS);
      // the unavailable data code yields no delay rather than a wrapped value
      if (du == 3'h0) begin
         nxt_data_ps = 16'h0000;
      end else begin
         nxt_data_ps = 16'(16'({13'h0, du} * step16) - DELAY_OFFSET_PS);
      end
   end

   // =============================================
   // registered outputs, zero outside low-power parallel mode
   always_ff @(posedge mclk) begin
      if (sys_rst || !lp_mode) begin
         delay_active <= 1'b0;
         data_sel_invalid <= 1'b0;
         outclk_delay_units <= 3'h0;
         outdata_delay_units <= 3'h0;
         unit_delay_ps <= 12'h000;
         outclk_delay_ps <= 16'h0000;
         outdata_delay_ps <= 16'h0000;
      end else begin
         delay_active <= 1'b1;
         data_sel_invalid <= (data_sel == DATA_SEL_NA);
         outclk_delay_units <= cu;
         outdata_delay_units <= du;
         unit_delay_ps <= step16[11:0];
         outclk_delay_ps <= nxt_clk_ps;
         outdata_delay_ps <= nxt_data_ps;
      end
   end

   // =============================================
   // checks
   AST_NA_NO_DELAY: assert property (@(posedge mclk) disable iff (sys_rst)
      (lp_mode && data_sel == DATA_SEL_NA) |=> (outdata_delay_ps == 16'h0000 && data_sel_invalid))
      else $error("unavailable data code produced a delay");
   AST_STEP_TIMES: assert property (@(posedge mclk) disable iff (sys_rst)
      (lp_mode && step_sel == 3'h2 && clk_sel == 2'h2) |=> (outclk_delay_ps == 16'h0320))
      else $error("clock delay 2 units of 0.55 ns wrong");
   AST_IDLE_ZERO: assert property (@(posedge mclk) disable iff (sys_rst)
      !lp_mode |=> (!delay_active && outclk_delay_ps == 16'h0000))
      else $error("delay active outside low power mode");
endmodule // lp_delay_decode
`default_nettype wire

// ==== core/aux_duplex_lpcmos_ctrl_regs.sv ====
`default_nettype none
module aux_duplex_lpcmos_ctrl_regs (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [11:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic powerdown_pin,
   input wire logic low_power_parallel_out,
   output logic aux_adc_wake,
   output logic aux_adc_powerdown,
   output logic aux_in_a_sel,
   output logic aux_in_b_sel,
   output logic duplex_by_pin_enable,
   output logic rx_shutdown,
   output logic tx_shutdown,
   output logic delay_active,
   output logic data_sel_invalid,
   output aux_ctrl_pkg::delay_units_t outclk_delay_units,
   output aux_ctrl_pkg::delay_units_t outdata_delay_units,
   output aux_ctrl_pkg::step_ps_t unit_delay_ps,
   output logic [15:0] outclk_delay_ps,
   output logic [15:0] outdata_delay_ps
);
   import aux_ctrl_pkg::*;

   logic aux_wake_ff;
   logic [1:0] aux_insel_ff;
   logic dup_en_ff;
   logic [1:0] clk_sel_ff;
   logic [2:0] data_sel_ff;
   logic [2:0] step_sel_ff;
   logic [7:0] nxt_rdata;

   // =============================================
   // register writes; only defined fields are stored, the rest read zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         aux_wake_ff <= REG_RESET_VALUE[AUX_WAKE_BIT];
         aux_insel_ff <= REG_RESET_VALUE[AUX_INSEL_LSB +: 2];
         dup_en_ff <= REG_RESET_VALUE[DUPLEX_BY_PIN_BIT];
         clk_sel_ff <= REG_RESET_VALUE[OUTCLK_SEL_LSB +: 2];
         data_sel_ff <= REG_RESET_VALUE[OUTDATA_SEL_LSB +: 3];
         step_sel_ff <= REG_RESET_VALUE[STEP_SEL_LSB +: 3];
      end else if (reg_wr) begin
         case (reg_addr)
            AUX_MONITOR_CONTROL_OFFS: begin
               aux_wake_ff <= reg_wdata[AUX_WAKE_BIT];
               aux_insel_ff <= reg_wdata[AUX_INSEL_LSB +: 2];
            end
            DUPLEX_PIN_CONTROL_OFFS: begin
               dup_en_ff <= reg_wdata[DUPLEX_BY_PIN_BIT];
            end
            LP_PARALLEL_CLOCK_DELAY_OFFS: begin
               clk_sel_ff <= reg_wdata[OUTCLK_SEL_LSB +: 2];
            end
            LP_PARALLEL_DATA_DELAY_OFFS: begin
               data_sel_ff <= reg_wdata[OUTDATA_SEL_LSB +: 3];
               step_sel_ff <= reg_wdata[STEP_SEL_LSB +: 3];
            end
            default: begin
            end
         endcase
      end
   end

   // =============================================
   // read back, one cycle after the strobe; unmapped addresses read zero
   always_comb begin
      nxt_rdata = 8'h00;
      case (reg_addr)
         AUX_MONITOR_CONTROL_OFFS: begin
            nxt_rdata[AUX_WAKE_BIT] = aux_wake_ff;
            nxt_rdata[AUX_INSEL_LSB +: 2] = aux_insel_ff;
         end
         DUPLEX_PIN_CONTROL_OFFS: nxt_rdata[DUPLEX_BY_PIN_BIT] = dup_en_ff;
         LP_PARALLEL_CLOCK_DELAY_OFFS: nxt_rdata[OUTCLK_SEL_LSB +: 2] = clk_sel_ff;
         LP_PARALLEL_DATA_DELAY_OFFS: begin
            nxt_rdata[OUTDATA_SEL_LSB +: 3] = data_sel_ff;
            nxt_rdata[STEP_SEL_LSB +: 3] = step_sel_ff;
         end
         default: nxt_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= nxt_rdata;
         end
      end
   end

   // =============================================
   // auxiliary converter control
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         aux_adc_wake <= 1'b0;
         aux_adc_powerdown <= 1'b1;
         aux_in_a_sel <= 1'b0;
         aux_in_b_sel <= 1'b0;
      end else begin
         aux_adc_wake <= aux_wake_ff;
         aux_adc_powerdown <= !aux_wake_ff;
         aux_in_a_sel <= (aux_insel_ff == AUX_IN_A);
         // reserved codes leave both external inputs disconnected
         aux_in_b_sel <= (aux_insel_ff == AUX_IN_B);
      end
   end

   // =============================================
   // half duplex by pin; pin is registered so the shutdowns are glitch free
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         duplex_by_pin_enable <= 1'b0;
         rx_shutdown <= 1'b0;
         tx_shutdown <= 1'b0;
      end else begin
         duplex_by_pin_enable <= dup_en_ff;
         rx_shutdown <= dup_en_ff && !powerdown_pin;
         tx_shutdown <= dup_en_ff && powerdown_pin;
      end
   end

   // =============================================
   // low-power parallel output delays
   lp_delay_decode u_delay (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .lp_mode(low_power_parallel_out),
      .clk_sel(clk_sel_ff),
      .data_sel(data_sel_ff),
      .step_sel(step_sel_ff),
      .delay_active(delay_active),
      .data_sel_invalid(data_sel_invalid),
      .outclk_delay_units(outclk_delay_units),
      .outdata_delay_units(outdata_delay_units),
      .unit_delay_ps(unit_delay_ps),
      .outclk_delay_ps(outclk_delay_ps),
      .outdata_delay_ps(outdata_delay_ps)
   );

   // =============================================
   // checks
   AST_WAKE_FOLLOWS: assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_addr == AUX_MONITOR_CONTROL_OFFS)
      |=> ##1 (aux_adc_wake == $past(reg_wdata[AUX_WAKE_BIT], 2) && aux_adc_powerdown != aux_adc_wake))
      else $error("aux wake does not follow written bit");
   AST_INSEL_A: assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_addr == AUX_MONITOR_CONTROL_OFFS && reg_wdata[4:3] == 2'h0)
      |=> ##1 (aux_in_a_sel && !aux_in_b_sel))
      else $error("input A not routed");
   AST_INSEL_B: assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_addr == AUX_MONITOR_CONTROL_OFFS && reg_wdata[4:3] == 2'h1)
      |=> ##1 (aux_in_b_sel && !aux_in_a_sel))
      else $error("input B not routed");
   AST_INSEL_RSVD: assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_addr == AUX_MONITOR_CONTROL_OFFS && reg_wdata[4])
      |=> ##1 (!aux_in_a_sel && !aux_in_b_sel))
      else $error("reserved selector code routed an input");
   AST_DUPLEX_RX: assert property (@(posedge mclk) disable iff (sys_rst)
      (dup_en_ff && powerdown_pin) |=> (tx_shutdown && !rx_shutdown))
      else $error("pin high did not select receive");
   AST_DUPLEX_TX: assert property (@(posedge mclk) disable iff (sys_rst)
      (dup_en_ff && !powerdown_pin) |=> (rx_shutdown && !tx_shutdown))
      else $error("pin low did not select transmit");
   AST_DUPLEX_OFF: assert property (@(posedge mclk) disable iff (sys_rst)
      !dup_en_ff |=> (!rx_shutdown && !tx_shutdown))
      else $error("pin acted while duplex by pin disabled");
   AST_CLK_DELAY: assert property (@(posedge mclk) disable iff (sys_rst)
      (low_power_parallel_out && clk_sel_ff == 2'h1) |=> (outclk_delay_units == 3'h5))
      else $error("clock delay code 01 not 5 units");
   AST_DATA_DELAY: assert property (@(posedge mclk) disable iff (sys_rst)
      (low_power_parallel_out && data_sel_ff == 3'h5) |=> (outdata_delay_units == 3'h1))
      else $error("data delay code 101 not 1 unit");
   AST_STEP_DEFAULT: assert property (@(posedge mclk) disable iff (sys_rst)
      (low_power_parallel_out && step_sel_ff == 3'h0) |=> (unit_delay_ps == 12'h460))
      else $error("unit delay code 000 not 1.12 ns");
   AST_READ_PULSE: assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_addr == 12'h371) |=> (reg_rvalid && reg_rdata == 8'h00))
      else $error("unmapped read not zero");
   AST_WAKE_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
      !aux_wake_ff |=> (aux_adc_powerdown && !aux_adc_wake))
      else $error("aux converter awake with wake bit clear");
   AST_WAKE_SET: assert property (@(posedge mclk) disable iff (sys_rst)
      aux_wake_ff |=> (aux_adc_wake && !aux_adc_powerdown))
      else $error("aux converter asleep with wake bit set");
   AST_RSVD_FIELD: assert property (@(posedge mclk) disable iff (sys_rst)
      aux_insel_ff[1] |=> (!aux_in_a_sel && !aux_in_b_sel))
      else $error("reserved selector field routed an input");
   AST_SHUTDOWN_EXCL: assert property (@(posedge mclk) disable iff (sys_rst)
      !(rx_shutdown && tx_shutdown))
      else $error("receive and transmit both shut down");
   AST_RDATA_DUPLEX: assert property (@(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_addr == DUPLEX_PIN_CONTROL_OFFS)
      |=> (reg_rvalid && reg_rdata == {5'h00, $past(dup_en_ff), 2'h0}))
      else $error("duplex enable read back wrong");
   AST_ACTIVE_MODE: assert property (@(posedge mclk) disable iff (sys_rst)
      low_power_parallel_out |=> delay_active)
      else $error("delays inactive in low power mode");
   AST_STEP_LAST: assert property (@(posedge mclk) disable iff (sys_rst)
      (low_power_parallel_out && step_sel_ff == 3'h7) |=> (unit_delay_ps == 12'h654))
      else $error("unit delay code 111 not 1.62 ns");

   // =============================================
   // scenario coverage

   COV_WAKE: cover property (@(posedge mclk) disable iff (sys_rst) $rose(aux_adc_wake));
   COV_RX_MODE: cover property (@(posedge mclk) disable iff (sys_rst) $rose(tx_shutdown));
   COV_NA_CODE: cover property (@(posedge mclk) disable iff (sys_rst) data_sel_invalid);
   COV_TX_MODE: cover property (@(posedge mclk) disable iff (sys_rst) $rose(rx_shutdown));
   COV_RSVD_SEL: cover property (@(posedge mclk) disable iff (sys_rst)
      aux_adc_wake && !aux_in_a_sel && !aux_in_b_sel);
endmodule // aux_duplex_lpcmos_ctrl_regs
`default_nettype wire

// ==== tb/tb_aux_duplex_lpcmos_ctrl_regs.sv ====
`default_nettype none
module tb_aux_duplex_lpcmos_ctrl_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import aux_ctrl_pkg::*;
   // =============================================
   // signals and reference state
   logic mclk, sys_rst, reg_wr, reg_rd, powerdown_pin, low_power_parallel_out;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic reg_rvalid, aux_adc_wake, aux_adc_powerdown, aux_in_a_sel, aux_in_b_sel;
   logic duplex_by_pin_enable, rx_shutdown, tx_shutdown, delay_active, data_sel_invalid;
   delay_units_t outclk_delay_units, outdata_delay_units;
   step_ps_t unit_delay_ps;
   logic [15:0] outclk_delay_ps, outdata_delay_ps;
   logic [7:0] m_aux, m_dup, m_clk, m_dat;
   logic [11:0] step_tab [8] = '{12'h460, 12'h5DC, 12'h226, 12'h384,
                                 12'h73A, 12'h898, 12'h4E2, 12'h654};
   logic [2:0] cu_tab [4] = '{3'h4, 3'h5, 3'h2, 3'h3};
   logic [2:0] du_tab [8] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1, 3'h2, 3'h3};
   // unmapped address in the last slot keeps ignored writes in the random mix
   logic [11:0] addr_tab [8] = '{AUX_MONITOR_CONTROL_OFFS, DUPLEX_PIN_CONTROL_OFFS,
      LP_PARALLEL_CLOCK_DELAY_OFFS, LP_PARALLEL_DATA_DELAY_OFFS, AUX_MONITOR_CONTROL_OFFS,
      LP_PARALLEL_CLOCK_DELAY_OFFS, LP_PARALLEL_DATA_DELAY_OFFS, 12'h36F};
   int error_cnt, checks_done, seed, i;

   aux_duplex_lpcmos_ctrl_regs i_aux_duplex_lpcmos_ctrl_regs (.mclk(mclk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .powerdown_pin(powerdown_pin),
      .low_power_parallel_out(low_power_parallel_out), .aux_adc_wake(aux_adc_wake),
      .aux_adc_powerdown(aux_adc_powerdown), .aux_in_a_sel(aux_in_a_sel),
      .aux_in_b_sel(aux_in_b_sel), .duplex_by_pin_enable(duplex_by_pin_enable),
      .rx_shutdown(rx_shutdown), .tx_shutdown(tx_shutdown), .delay_active(delay_active),
      .data_sel_invalid(data_sel_invalid), .outclk_delay_units(outclk_delay_units),
      .outdata_delay_units(outdata_delay_units), .unit_delay_ps(unit_delay_ps),
      .outclk_delay_ps(outclk_delay_ps), .outdata_delay_ps(outdata_delay_ps));

   // =============================================
   // helpers
   function automatic logic [15:0] f_ps(input logic [2:0] u, input logic [11:0] st);
      return (u == 3'h0) ? 16'h0000 : 16'(u) * 16'(st) - 16'h012C;
   endfunction

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // write strobe is left high so writes can follow each other every cycle
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      reg_wr = 1'b1;
      reg_rd = 1'b0;
      reg_addr = a;
      reg_wdata = d;
      @(negedge mclk);
      case (a)
         AUX_MONITOR_CONTROL_OFFS: m_aux = d & 8'h58;
         DUPLEX_PIN_CONTROL_OFFS: m_dup = d & 8'h04;
         LP_PARALLEL_CLOCK_DELAY_OFFS: m_clk = d & 8'h03;
         LP_PARALLEL_DATA_DELAY_OFFS: m_dat = d & 8'h3F;
         default: m_aux = m_aux;
      endcase
   endtask

   task automatic idle(input int n);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (n) @(negedge mclk);
   endtask

   // read strobe stays high like the write strobe; the answer stands one cycle after it
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge mclk);
      chk("rvalid", reg_rvalid, 1'b1);
      chk("rdata", reg_rdata, exp);
   endtask

   task automatic rd_all();
      rd(AUX_MONITOR_CONTROL_OFFS, m_aux);
      rd(DUPLEX_PIN_CONTROL_OFFS, m_dup);
      rd(LP_PARALLEL_CLOCK_DELAY_OFFS, m_clk);
      rd(LP_PARALLEL_DATA_DELAY_OFFS, m_dat);
      rd(12'h371, 8'h00);
   endtask

   task automatic chk_out();
      logic lp;
      logic [2:0] cu, du;
      logic [11:0] st;
      lp = low_power_parallel_out;
      cu = lp ? cu_tab[m_clk[1:0]] : 3'h0;
      du = lp ? du_tab[m_dat[2:0]] : 3'h0;
      st = lp ? step_tab[m_dat[5:3]] : 12'h000;
      chk("wake", aux_adc_wake, m_aux[6]);
      chk("pdown", aux_adc_powerdown, !m_aux[6]);
      chk("in_a", aux_in_a_sel, m_aux[4:3] == 2'h0);
      chk("in_b", aux_in_b_sel, m_aux[4:3] == 2'h1);
      chk("dbp_en", duplex_by_pin_enable, m_dup[2]);
      chk("rx_sd", rx_shutdown, m_dup[2] & !powerdown_pin);
      chk("tx_sd", tx_shutdown, m_dup[2] & powerdown_pin);
      chk("active", delay_active, lp);
      chk("invalid", data_sel_invalid, lp & (m_dat[2:0] == 3'h4));
      chk("clk_units", outclk_delay_units, cu);
      chk("dat_units", outdata_delay_units, du);
      chk("unit_ps", unit_delay_ps, st);
      chk("clk_ps", outclk_delay_ps, f_ps(cu, st));
      chk("dat_ps", outdata_delay_ps, f_ps(du, st));
   endtask

   // =============================================
   // clock, watchdog, sequence
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   initial begin
      #400000;
      error_cnt++;
      conclude();
   end

   initial begin
      seed = 32'hbd98;
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 12'h000;
      reg_wdata = 8'h00;
      powerdown_pin = 1'b0;
      low_power_parallel_out = 1'b1;
      {m_aux, m_dup, m_clk, m_dat} = 32'h0000_0000;
      repeat (8) @(negedge mclk);
      chk("pdown_rst", aux_adc_powerdown, 1'b1);
      sys_rst = 1'b0;
      idle(1);
      chk_out();
      rd_all();
      // every code of every field, back-to-back writes, read right behind a write
      for (i = 0; i < 8; i++) begin
         wr(LP_PARALLEL_DATA_DELAY_OFFS, 8'(i * 9));
         wr(LP_PARALLEL_CLOCK_DELAY_OFFS, 8'(i));
         rd(LP_PARALLEL_CLOCK_DELAY_OFFS, m_clk);
         wr(AUX_MONITOR_CONTROL_OFFS, 8'(i * 8 + (i % 2) * 64));
         wr(DUPLEX_PIN_CONTROL_OFFS, 8'(i * 2));
         powerdown_pin = i[0];
         idle(3);
         chk_out();
      end
      // random traffic, pin and mode toggling, unmapped writes ignored
      for (i = 0; i < 60; i++) begin
         wr(addr_tab[3'($random(seed))], 8'($random(seed)));
         {powerdown_pin, low_power_parallel_out} = 2'($random(seed));
         idle(3);
         chk_out();
         if (i % 8 == 0) begin
            rd_all();
         end
      end
      // reset in mid-run returns every register to zero
      wr(AUX_MONITOR_CONTROL_OFFS, 8'hFF);
      wr(LP_PARALLEL_DATA_DELAY_OFFS, 8'h24);
      sys_rst = 1'b1;
      idle(2);
      chk("pdown_rst", aux_adc_powerdown, 1'b1);
      chk("wake_rst", aux_adc_wake, 1'b0);
      sys_rst = 1'b0;
      {m_aux, m_dup, m_clk, m_dat} = 32'h0000_0000;
      low_power_parallel_out = 1'b1;
      idle(3);
      chk_out();
      rd_all();
      conclude();
   end
endmodule // tb_aux_duplex_lpcmos_ctrl_regs
`default_nettype wire
